// File: core/dmpc_core.sv
`timescale 1ns/1ps
module dmpc_core #(
  parameter int STACK_DEPTH = 5
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Data-memory access from the CPU
  input wire dmpc_pkg::dmpc_dreq_t dreq,
  output logic [7:0] rdata,
  // Dedicated write instructions
  input wire logic dir_wr,
  input wire logic opt_wr,
  input wire logic [7:0] dir_opt_data,
  // Program flow
  input wire dmpc_pkg::dmpc_flow_t flow,
  output logic [9:0] pc,
  // Peripheral side
  input wire logic [7:0] timer_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic [7:0] int_flags_in,
  output logic [7:0] port_a_latch,
  output logic [7:0] port_b_latch,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] timer_option_config,
  output logic [7:0] power_control,
  output logic [7:0] wakeup_change_enable,
  output logic [7:0] pulldown_control,
  output logic [7:0] opendrain_control,
  output logic [7:0] pullup_control,
  output logic [7:0] interrupt_enable,
  output logic [7:0] status_wr,
  output logic [7:0] timer_wr,
  output logic [7:0] int_flags_wr,
  output logic status_wr_en,
  output logic timer_wr_en,
  output logic int_flags_wr_en
);
  import dmpc_pkg::*;

  initial begin
    if (STACK_DEPTH < 2) $error("dmpc_core: STACK_DEPTH below 2");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and state
  // ---------------------------------------------------------------
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic [7:0] ptr_q, pchb_q, gpb_q;
  logic [7:0] gpr_q [64];
  logic [9:0] pc_q;
  logic [7:0] rdata_q;
  logic [5:0] eff_addr;
  logic self_ind;
  logic [7:0] rd_d;
  logic [9:0] pc_d;
  logic [9:0] stk_top;
  logic push, pop;
  logic wr_pcl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_s1_q <= DMPC_BYTE_RST;
      pa_s2_q <= DMPC_BYTE_RST;
      pb_s1_q <= DMPC_BYTE_RST;
      pb_s2_q <= DMPC_BYTE_RST;
    end else if (ce) begin
      pa_s1_q <= port_a_pins;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_pins;
      pb_s2_q <= pb_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Address resolution
  // ---------------------------------------------------------------
  // Pointer upper bits are forced to ones, so only bits 5:0 matter
  assign self_ind = (dreq.addr == DMPC_A_IND) && (ptr_q[5:0] == DMPC_A_IND);
  assign eff_addr = (dreq.addr == DMPC_A_IND) ? ptr_q[5:0] : dreq.addr;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    if (self_ind) begin
      rd_d = 8'h00;
    end else if (eff_addr >= DMPC_A_GPR_LO) begin
      rd_d = gpr_q[eff_addr];
    end else if (eff_addr == DMPC_A_TMR) begin
      rd_d = timer_in;
    end else if (eff_addr == DMPC_A_PCL) begin
      rd_d = pc_q[7:0];
    end else if (eff_addr == DMPC_A_STAT) begin
      rd_d = status_in;
    end else if (eff_addr == DMPC_A_PTR) begin
      rd_d = ptr_q | DMPC_PTR_ONES;
    end else if (eff_addr == DMPC_A_PA) begin
      rd_d = {port_a_latch[7:4], pa_s2_q[3:0]};
    end else if (eff_addr == DMPC_A_PB) begin
      rd_d = pb_s2_q;
    end else if (eff_addr == DMPC_A_GPB) begin
      rd_d = gpb_q;
    end else if (eff_addr == DMPC_A_PWR) begin
      rd_d = power_control | DMPC_PWR_ONES;
    end else if (eff_addr == DMPC_A_WUC) begin
      rd_d = wakeup_change_enable;
    end else if (eff_addr == DMPC_A_PCHB) begin
      rd_d = pchb_q & ~DMPC_PCHB_ZERO;
    end else if (eff_addr == DMPC_A_PDN) begin
      rd_d = pulldown_control;
    end else if (eff_addr == DMPC_A_ODC) begin
      rd_d = opendrain_control;
    end else if (eff_addr == DMPC_A_PUP) begin
      rd_d = pullup_control;
    end else if (eff_addr == DMPC_A_IEN) begin
      rd_d = interrupt_enable | DMPC_IEN_ONES;
    end else if (eff_addr == DMPC_A_IFL) begin
      rd_d = int_flags_in & ~DMPC_IFL_ZERO;
    end else begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= DMPC_BYTE_RST;
    end else if (ce && dreq.rd) begin
      rdata_q <= rd_d;
    end
  end
  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  logic wen;
  // A self-pointing indirect write is dropped; flags are the ALU's business
  assign wen = ce && dreq.wr && !self_ind;

  always_ff @(posedge clk) begin
    if (wen && eff_addr >= DMPC_A_GPR_LO) begin
      gpr_q[eff_addr] <= dreq.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= DMPC_PTR_ONES;
      pchb_q <= DMPC_BYTE_RST;
      gpb_q <= DMPC_BYTE_RST;
      port_a_latch <= DMPC_BYTE_RST;
      port_b_latch <= DMPC_BYTE_RST;
      power_control <= DMPC_PWR_ONES;
      wakeup_change_enable <= DMPC_BYTE_RST;
      pulldown_control <= DMPC_BYTE_RST;
      opendrain_control <= DMPC_BYTE_RST;
      pullup_control <= DMPC_BYTE_RST;
      interrupt_enable <= DMPC_IEN_ONES;
    end else if (wen) begin
      case (eff_addr)
        DMPC_A_PTR: ptr_q <= dreq.wdata | DMPC_PTR_ONES;
        DMPC_A_PCHB: pchb_q <= dreq.wdata & ~DMPC_PCHB_ZERO;
        DMPC_A_GPB: gpb_q <= dreq.wdata;
        DMPC_A_PA: port_a_latch <= dreq.wdata;
        DMPC_A_PB: port_b_latch <= dreq.wdata;
        DMPC_A_PWR: power_control <= dreq.wdata | DMPC_PWR_ONES;
        DMPC_A_WUC: wakeup_change_enable <= dreq.wdata;
        DMPC_A_PDN: pulldown_control <= dreq.wdata;
        DMPC_A_ODC: opendrain_control <= dreq.wdata;
        DMPC_A_PUP: pullup_control <= dreq.wdata;
        DMPC_A_IEN: interrupt_enable <= dreq.wdata | DMPC_IEN_ONES;
        default: ;
      endcase
    end
  end

  // Writes to timer, status and flags are forwarded to their owners
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_wr <= DMPC_BYTE_RST;
      timer_wr <= DMPC_BYTE_RST;
      int_flags_wr <= DMPC_BYTE_RST;
      status_wr_en <= 1'b0;
      timer_wr_en <= 1'b0;
      int_flags_wr_en <= 1'b0;
    end else if (ce) begin
      status_wr <= dreq.wdata;
      timer_wr <= dreq.wdata;
      int_flags_wr <= dreq.wdata & ~DMPC_IFL_ZERO;
      status_wr_en <= wen && eff_addr == DMPC_A_STAT;
      timer_wr_en <= wen && eff_addr == DMPC_A_TMR;
      int_flags_wr_en <= wen && eff_addr == DMPC_A_IFL;
    end
  end

  // Direction page and option: reachable only by their own instructions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a_direction <= DMPC_DIR_RST;
      port_b_direction <= DMPC_DIR_RST;
      timer_option_config <= DMPC_OPT_RST;
    end else if (ce) begin
      if (dir_wr && dreq.addr == DMPC_A_PA) begin
        port_a_direction <= dir_opt_data;
      end else if (dir_wr && dreq.addr == DMPC_A_PB) begin
        port_b_direction <= dir_opt_data;
      end
      if (opt_wr) begin
        timer_option_config <= dir_opt_data | DMPC_OPT_ONES;
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  assign wr_pcl = wen && eff_addr == DMPC_A_PCL;
  assign push = flow.valid && flow.op == DMPC_PC_CALL;
  assign pop = flow.valid && flow.op == DMPC_PC_RET;

  always_comb begin
    pc_d = pc_q + 10'h001;
    if (wr_pcl) begin
      pc_d = {pchb_q[1:0], dreq.wdata};
    end else if (flow.valid) begin
      case (flow.op)
        DMPC_PC_JUMP: pc_d = flow.target;
        DMPC_PC_CALL: pc_d = flow.target;
        DMPC_PC_RET: pc_d = stk_top;
        DMPC_PC_HOLD: pc_d = pc_q;
        DMPC_PC_HWINT: pc_d = DMPC_HW_INT_VEC;
        DMPC_PC_SWINT: pc_d = DMPC_SW_INT_VEC;
        default: pc_d = pc_q + 10'h001;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= DMPC_RESET_VEC;
    end else if (ce) begin
      pc_q <= pc_d;
    end
  end
  assign pc = pc_q;

  dmpc_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(10)
  ) u_stack (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .push(push),
    .pop(pop),
    .push_data(pc_q + 10'h001),
    .top_data(stk_top)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // A low-byte write overrides the flow op's pc load (the stack still moves), so it must be absent here
  sequence s_call;
    ce && flow.valid && flow.op == DMPC_PC_CALL && !wr_pcl;
  endsequence
  sequence s_ret;
    ce && flow.valid && flow.op == DMPC_PC_RET && !wr_pcl;
  endsequence
  // Any taken cycle that leaves the stack alone
  sequence s_quiet;
    ce && !push && !pop;
  endsequence

  a_reset_vector: assert property (@(posedge clk) $fell(rst) |-> pc_q == DMPC_RESET_VEC)
    else $error("pc not at reset vector");
  a_pc_step: assert property (@(posedge clk) disable iff (rst)
    ce && !wr_pcl && (!flow.valid || flow.op == DMPC_PC_STEP)
    |=> pc_q == $past(pc_q) + 10'h001)
    else $error("pc did not advance");
  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> pc_q == $past(pc_q) && ptr_q == $past(ptr_q))
    else $error("state moved with clock enable low");
  a_jump_load: assert property (@(posedge clk) disable iff (rst)
    ce && flow.valid && flow.op == DMPC_PC_JUMP && !wr_pcl
    |=> pc_q == $past(flow.target) && pchb_q == $past(pchb_q))
    else $error("jump load wrong");
  a_call_return: assert property (@(posedge clk) disable iff (rst)
    s_call ##1 s_quiet ##1 s_ret |=> pc_q == $past(pc_q, 3) + 10'h001)
    else $error("return address wrong");
  a_pcl_write: assert property (@(posedge clk) disable iff (rst)
    wr_pcl |=> pc_q == {$past(pchb_q[1:0]), $past(dreq.wdata)})
    else $error("pcl write wrong");
  a_pcl_read: assert property (@(posedge clk) disable iff (rst)
    ce && dreq.rd && eff_addr == DMPC_A_PCL |=> rdata_q == $past(pc_q[7:0]))
    else $error("pcl read wrong");
  a_ind_zero: assert property (@(posedge clk) disable iff (rst)
    ce && dreq.rd && self_ind |=> rdata_q == 8'h00)
    else $error("self indirect read not zero");
  a_dir_write: assert property (@(posedge clk) disable iff (rst)
    ce && dir_wr && dreq.addr == DMPC_A_PA |=> port_a_direction == $past(dir_opt_data))
    else $error("direction write lost");
  a_dir_guard: assert property (@(posedge clk) disable iff (rst)
    !(ce && dir_wr) |=> port_a_direction == $past(port_a_direction))
    else $error("direction changed without its op");
  a_ptr_ones: assert property (@(posedge clk) disable iff (rst)
    ptr_q[7:6] == 2'b11)
    else $error("pointer upper bits not ones");
  a_pchb_hold: assert property (@(posedge clk) disable iff (rst)
    !(wen && eff_addr == DMPC_A_PCHB) |=> pchb_q == $past(pchb_q))
    else $error("high buffer changed by hardware");
  a_int_vector: assert property (@(posedge clk) disable iff (rst)
    ce && flow.valid && flow.op == DMPC_PC_HWINT && !wr_pcl
    |=> pc_q == DMPC_HW_INT_VEC)
    else $error("interrupt vector wrong");
  a_swint_vector: assert property (@(posedge clk) disable iff (rst)
    ce && flow.valid && flow.op == DMPC_PC_SWINT && !wr_pcl
    |=> pc_q == DMPC_SW_INT_VEC)
    else $error("software vector wrong");
endmodule

// File: core/dmpc_pkg.sv
package dmpc_pkg;
  // ---------------------------------------------------------------
  // Data-memory map
  // ---------------------------------------------------------------
  localparam logic [5:0] DMPC_A_IND = 6'h00;
  localparam logic [5:0] DMPC_A_TMR = 6'h01;
  localparam logic [5:0] DMPC_A_PCL = 6'h02;
  localparam logic [5:0] DMPC_A_STAT = 6'h03;
  localparam logic [5:0] DMPC_A_PTR = 6'h04;
  localparam logic [5:0] DMPC_A_PA = 6'h05;
  localparam logic [5:0] DMPC_A_PB = 6'h06;
  localparam logic [5:0] DMPC_A_GPB = 6'h07;
  localparam logic [5:0] DMPC_A_PWR = 6'h08;
  localparam logic [5:0] DMPC_A_WUC = 6'h09;
  localparam logic [5:0] DMPC_A_PCHB = 6'h0a;
  localparam logic [5:0] DMPC_A_PDN = 6'h0b;
  localparam logic [5:0] DMPC_A_ODC = 6'h0c;
  localparam logic [5:0] DMPC_A_PUP = 6'h0d;
  localparam logic [5:0] DMPC_A_IEN = 6'h0e;
  localparam logic [5:0] DMPC_A_IFL = 6'h0f;
  localparam logic [5:0] DMPC_A_GPR_LO = 6'h10;
  // ---------------------------------------------------------------
  // Fixed-bit masks: ones_mask reads 1, zero_mask reads 0
  // ---------------------------------------------------------------
  localparam logic [7:0] DMPC_PTR_ONES = 8'hc0;
  localparam logic [7:0] DMPC_PWR_ONES = 8'h1f;
  localparam logic [7:0] DMPC_IEN_ONES = 8'h78;
  localparam logic [7:0] DMPC_PCHB_ZERO = 8'hfc;
  localparam logic [7:0] DMPC_IFL_ZERO = 8'hf8;
  localparam logic [7:0] DMPC_OPT_ONES = 8'h80;
  // ---------------------------------------------------------------
  // Program counter vectors and reset values
  // ---------------------------------------------------------------
  localparam logic [9:0] DMPC_RESET_VEC = 10'h3ff;
  localparam logic [9:0] DMPC_HW_INT_VEC = 10'h008;
  localparam logic [9:0] DMPC_SW_INT_VEC = 10'h002;
  localparam logic [7:0] DMPC_BYTE_RST = 8'h00;
  localparam logic [7:0] DMPC_DIR_RST = 8'hff;
  localparam logic [7:0] DMPC_OPT_RST = 8'hff;
  // ---------------------------------------------------------------
  // Program-flow operations from the CPU
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DMPC_PC_STEP = 3'h0,
    DMPC_PC_JUMP = 3'h1,
    DMPC_PC_CALL = 3'h2,
    DMPC_PC_RET = 3'h3,
    DMPC_PC_HOLD = 3'h4,
    DMPC_PC_HWINT = 3'h5,
    DMPC_PC_SWINT = 3'h6
  } dmpc_pcop_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dmpc_dreq_t;

  typedef struct packed {
    logic valid;
    dmpc_pcop_t op;
    logic [9:0] target;
  } dmpc_flow_t;
endpackage

// File: core/dmpc_stack.sv
`timescale 1ns/1ps
module dmpc_stack #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 10
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("dmpc_stack: bad DEPTH or WIDTH");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] top_q;
  logic [PW-1:0] up;

  // Circular pointer: a push past entry DEPTH (the fifth by default) overwrites the oldest
  assign up = (top_q == LAST) ? '0 : top_q + PW'(1);
  assign top_data = mem_q[top_q];

  // ---------------------------------------------------------------
  // Pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_q <= LAST;
    end else if (ce) begin
      if (push) begin
        top_q <= up;
      end else if (pop) begin
        top_q <= (top_q == '0) ? LAST : top_q - PW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_q[i] <= '0;
        end else if (ce && push && up == PW'(i)) begin
          mem_q[i] <= push_data;
        end
      end
    end
  endgenerate
endmodule

// File: verif/dmpc_cpu_model.sv
`timescale 1ns/1ps
module dmpc_cpu_model (
  // Clocking
  input wire logic clk,
  output logic ce,
  // Data access
  output dmpc_pkg::dmpc_dreq_t dreq,
  input wire logic [7:0] rdata,
  // Dedicated writes
  output logic dir_wr,
  output logic opt_wr,
  output logic [7:0] dir_opt_data,
  // Program flow
  output dmpc_pkg::dmpc_flow_t flow
);
  import dmpc_pkg::*;

  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  // Hold op parks the pc, so checks never race the free-running step
  initial begin
    ce = 1'b1;
    dreq = '0;
    flow = '{1'b1, DMPC_PC_HOLD, 10'h000};
    dir_wr = 1'b0;
    opt_wr = 1'b0;
    dir_opt_data = 8'h00;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    dreq <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    dreq <= '0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    dreq <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk);
    dreq <= '0;
    #1;
    d = rdata;
  endtask

  task automatic dir(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    dir_wr <= 1'b1;
    dreq <= '{1'b0, 1'b0, a, 8'h00};
    dir_opt_data <= d;
    @(posedge clk);
    dir_wr <= 1'b0;
    dreq <= '0;
    #1;
  endtask

  task automatic opt(input logic [7:0] d);
    @(posedge clk);
    opt_wr <= 1'b1;
    dir_opt_data <= d;
    @(posedge clk);
    opt_wr <= 1'b0;
    #1;
  endtask

  // One cycle with the clock enable low: write and step must both be lost
  task automatic stall(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    ce <= 1'b0;
    dreq <= '{1'b0, 1'b1, a, d};
    flow <= '{1'b1, DMPC_PC_STEP, 10'h000};
    @(posedge clk);
    ce <= 1'b1;
    dreq <= '0;
    flow <= '{1'b1, DMPC_PC_HOLD, 10'h000};
    #1;
  endtask

  task automatic pc_op(input dmpc_pcop_t op, input logic [9:0] t);
    @(posedge clk);
    flow <= '{1'b1, op, t};
    @(posedge clk);
    flow <= '{1'b1, DMPC_PC_HOLD, 10'h000};
    #1;
  endtask
endmodule

// File: verif/tb_data_memory_and_pc_logic.sv
`timescale 1ns/1ps
module tb_data_memory_and_pc_logic;
  import dmpc_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce;
  dmpc_dreq_t dreq;
  dmpc_flow_t flow;
  logic dir_wr;
  logic opt_wr;
  logic [7:0] dir_opt_data;
  logic [7:0] rdata;
  logic [9:0] pc;
  logic [7:0] pa_lat;
  logic [7:0] pa_dir;
  logic [7:0] pb_dir;
  logic [7:0] opt_cfg;
  logic [7:0] v;
  logic [7:0] pins = 8'ha5;
  logic [7:0] st_wr;
  logic st_wr_en;
  int err_count = 0;
  int num_checks = 0;
  // Address, written value, expected read-back
  localparam logic [21:0] REG_TBL [6] = '{
    {DMPC_A_PWR, 8'h00, 8'h1f}, {DMPC_A_IEN, 8'h00, 8'h78},
    {DMPC_A_PCHB, 8'hff, 8'h03}, {DMPC_A_PTR, 8'h00, 8'hc0},
    {DMPC_A_PDN, 8'ha5, 8'ha5}, {DMPC_A_GPB, 8'h5a, 8'h5a}};

  always #2 clk = ~clk;

  // ---------------------------------------------------------------
  // Design and partner
  // ---------------------------------------------------------------
  // Timer, status and flag inputs are constants: their owners are other blocks
  dmpc_core DUT (.clk(clk), .rst(rst), .ce(ce), .dreq(dreq), .rdata(rdata),
    .dir_wr(dir_wr), .opt_wr(opt_wr), .dir_opt_data(dir_opt_data), .flow(flow),
    .pc(pc), .timer_in(8'h3c), .status_in(8'h18), .port_a_pins(pins),
    .port_b_pins(~pins), .int_flags_in(8'hff), .port_a_latch(pa_lat),
    .port_b_latch(), .port_a_direction(pa_dir), .port_b_direction(pb_dir),
    .timer_option_config(opt_cfg), .power_control(), .wakeup_change_enable(),
    .pulldown_control(), .opendrain_control(), .pullup_control(),
    .interrupt_enable(), .status_wr(st_wr), .timer_wr(), .int_flags_wr(),
    .status_wr_en(st_wr_en), .timer_wr_en(), .int_flags_wr_en());

  dmpc_cpu_model cpu (.clk(clk), .ce(ce), .dreq(dreq), .rdata(rdata),
    .dir_wr(dir_wr), .opt_wr(opt_wr), .dir_opt_data(dir_opt_data), .flow(flow));

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pc(input logic [9:0] e);
    num_checks++;
    if (pc !== e) begin
      err_count++;
      $display("mismatch pc expected %h seen %h", e, pc);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    cpu.rd(a, v);
    chk_byte("rdata", e, v);
  endtask

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_pc(DMPC_RESET_VEC);
    chk_byte("port_a_direction", 8'hff, pa_dir);
    cpu.pc_op(DMPC_PC_STEP, 10'h000);
    chk_pc(10'h000);
    for (int i = 0; i < 6; i++) begin
      cpu.wr(REG_TBL[i][21:16], REG_TBL[i][15:8]);
      rd_chk(REG_TBL[i][21:16], REG_TBL[i][7:0]);
    end
    rd_chk(DMPC_A_IFL, 8'h07);
    // Indirect walk, then the self-pointing corner
    cpu.wr(6'h22, 8'h25);
    cpu.wr(6'h23, 8'h3a);
    cpu.wr(DMPC_A_PTR, 8'h22);
    rd_chk(DMPC_A_PTR, 8'he2);
    rd_chk(DMPC_A_IND, 8'h25);
    cpu.wr(DMPC_A_PTR, 8'h23);
    rd_chk(DMPC_A_IND, 8'h3a);
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_TMR});
    rd_chk(DMPC_A_IND, 8'h3c);
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_STAT});
    cpu.wr(DMPC_A_IND, 8'he7);
    chk_byte("status_wr", 8'he7, st_wr);
    chk_byte("status_wr_en", 8'h01, {7'h00, st_wr_en});
    cpu.wr(DMPC_A_PTR, 8'h3f);
    cpu.wr(DMPC_A_IND, 8'h77);
    rd_chk(6'h3f, 8'h77);
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_PCHB});
    rd_chk(DMPC_A_IND, 8'h03);
    cpu.wr(DMPC_A_PTR, 8'h00);
    rd_chk(DMPC_A_IND, 8'h00);
    cpu.wr(DMPC_A_IND, 8'h99);
    rd_chk(DMPC_A_PTR, 8'hc0);
    rd_chk(DMPC_A_IND, 8'h00);
    // Program counter loads
    cpu.pc_op(DMPC_PC_JUMP, 10'h0a0);
    chk_pc(10'h0a0);
    rd_chk(DMPC_A_PCHB, 8'h03);
    rd_chk(DMPC_A_PCL, 8'ha0);
    cpu.wr(DMPC_A_PCL, 8'h55);
    chk_pc(10'h355);
    cpu.wr(DMPC_A_PCHB, 8'h01);
    cpu.pc_op(DMPC_PC_JUMP, 10'h2ff);
    rd_chk(DMPC_A_PCHB, 8'h01);
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_PCL});
    cpu.wr(DMPC_A_IND, 8'h20);
    chk_pc(10'h120);
    // Six calls into a five-deep stack: the oldest return is lost
    cpu.pc_op(DMPC_PC_JUMP, 10'h000);
    for (int k = 1; k <= 6; k++) begin
      cpu.pc_op(DMPC_PC_CALL, 10'(k * 16));
      chk_pc(10'(k * 16));
    end
    for (int k = 5; k >= 1; k--) begin
      cpu.pc_op(DMPC_PC_RET, 10'h000);
      chk_pc(10'(k * 16 + 1));
    end
    rd_chk(DMPC_A_PCHB, 8'h01);
    cpu.pc_op(DMPC_PC_HWINT, 10'h000);
    chk_pc(DMPC_HW_INT_VEC);
    cpu.pc_op(DMPC_PC_SWINT, 10'h000);
    chk_pc(DMPC_SW_INT_VEC);
    // Clock enable low: the write and the step are both lost
    cpu.stall(6'h22, 8'hc3);
    chk_pc(DMPC_SW_INT_VEC);
    rd_chk(6'h22, 8'h25);
    // Direction and option pages
    cpu.wr(DMPC_A_PA, 8'h3c);
    chk_byte("port_a_direction", 8'hff, pa_dir);
    chk_byte("port_a_latch", 8'h3c, pa_lat);
    // Pins need two synchroniser stages; the pointer writes give them time
    @(posedge clk);
    pins <= 8'h69;
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_PA});
    rd_chk(DMPC_A_IND, 8'h39);
    cpu.wr(DMPC_A_PTR, {2'b00, DMPC_A_PB});
    rd_chk(DMPC_A_IND, 8'h96);
    cpu.dir(DMPC_A_PA, 8'h0f);
    chk_byte("port_a_direction", 8'h0f, pa_dir);
    cpu.dir(DMPC_A_PB, 8'h3c);
    chk_byte("port_b_direction", 8'h3c, pb_dir);
    cpu.opt(8'h00);
    chk_byte("timer_option_config", 8'h80, opt_cfg);
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_pc(DMPC_RESET_VEC);
    chk_byte("port_a_direction", 8'hff, pa_dir);
    rd_chk(DMPC_A_PTR, 8'hc0);
    results();
  end
endmodule
